// ==== design/dmacm_top.sv ====
// Contract
// - Circular: reload count at zero, continue
// - Memory-to-memory only on channel 3
// - M2M starts on enable, ignores requests
// - M2M stops when count reaches zero
// - M2M ignores circular bit
// - M2M ignores direction: pointer0 to pointer1
// - M2M source increments, destination per step
// - Regular channels peripheral window 5200-53FF
// - Regular channels RAM 0000-07FF only
// - Channel 3 peripheral window 4000-5FFF
// - M2M destination within 0000-1FFF
// - Channel or global enable suspends anytime
// - Disable completes current item first
// - Re-enable unchanged resumes transaction
// - Count rewritten while suspended restarts fresh (code drops count writes while channel enable is on, even with global off)
// - Channel request is OR of mapped
// - Converter request remap bits [1:0]
// - Timer4 request remap bits [3:2]
// - Fixed per-channel peripheral mapping ORed
// - Count decrements per completed item
// - Non-circular: no requests after zero
// - Half and complete flags with enables
`timescale 1ns/100ps
module dmacm_top (
  input  wire logic                     mclk,        // System clock
  input  wire logic                     rst_b,       // Sync reset, active low
  input  wire logic                     clk_en,      // Freezes all state when low
  input  wire logic [3:0]               reg_addr,    // Register word address
  input  wire logic [15:0]              reg_wdata,   // Write data
  input  wire logic                     reg_wr,      // Write strobe
  input  wire logic                     reg_rd,      // Read strobe
  output      logic [15:0]              reg_rdata,   // Read data, cycle after strobe
  input  wire dmacm_pkg::dmacm_req_type periph_req [4], // Peripheral requests per channel
  output      dmacm_pkg::dmacm_xfer_type xfer,       // Item transfer to bus
  input  wire logic                     xfer_done,   // Bus finished the item
  output      logic [3:0]               chan_req,    // Mapped request per channel
  output      logic [3:0]               irq_ch       // Per-channel flag interrupt
);
  import dmacm_pkg::*;

  typedef struct packed {
    dmacm_ch_type [3:0] ch;
    logic               gen;
    logic [3:0]         remap;
    dmacm_state_type    state;
    logic [1:0]         cur;
    dmacm_xfer_type     xfer;
    logic [15:0]        rdata;
  } dmacm_st_type;

  dmacm_st_type st;
  dmacm_st_type next_st;

  logic [3:0] active;
  logic [3:0] m2m;
  logic [3:0] want;
  logic       pick_ok;
  logic [1:0] pick;

  // Request mux with remappable converter and timer requests
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chan_req[i] = |periph_req[i].fixed_req
                  | (periph_req[0].adc_eoc && st.remap[RMP_ADC_LO +: 2] == 2'(i))
                  | (periph_req[0].timer4_update_request
                     && st.remap[RMP_TIM_LO +: 2] == 2'(i));
    end
  end

  always_comb begin
    pick_ok = 1'b0;
    pick    = 2'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      m2m[i]    = (i == MEM_CH) && st.ch[i].ctrl[CTL_MEM];
      active[i] = st.gen && st.ch[i].ctrl[CTL_EN] && st.ch[i].cnt != 8'h00;
      want[i]   = active[i] && (m2m[i] || chan_req[i]);
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (want[i]) begin
        pick_ok = 1'b1;
        pick    = 2'(i);
      end
    end
  end

  function automatic logic addr_ok(input int i, input logic m, input logic [15:0] p,
                                   input logic [15:0] a);
    logic ok;
    ok = 1'b0;
    if (m)
      ok = p <= M2M_DST_HI;
    else if (i == MEM_CH)
      ok = p >= MEM_PER_LO && p <= MEM_PER_HI;
    else
      ok = p >= REG_PER_LO && p <= REG_PER_HI && a <= REG_RAM_HI;
    return ok;
  endfunction

  always_comb begin
    logic [1:0] c;
    logic       step_dn;
    next_st = st;
    c       = st.cur;
    step_dn = st.ch[c].ctrl[CTL_STEP];
    next_st.rdata = 16'h0000;
    if (reg_wr && reg_addr == OFF_STATUS) begin
      // Clear before the set below, so a same-cycle set wins
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_wdata[2*i])
          next_st.ch[i].htf = 1'b0;
        if (reg_wdata[2*i+1])
          next_st.ch[i].tcf = 1'b0;
      end
    end
    case (st.state)
      ST_IDLE: begin
        if (pick_ok) begin
          next_st.cur        = pick;
          next_st.state      = ST_BUSY;
          next_st.xfer.valid = addr_ok(int'(pick), m2m[pick], st.ch[pick].pptr, st.ch[pick].mptr);
          next_st.xfer.ch    = pick;
          if (m2m[pick] || !st.ch[pick].ctrl[CTL_DIR]) begin
            next_st.xfer.src = m2m[pick] ? st.ch[pick].mptr : st.ch[pick].pptr;
            next_st.xfer.dst = m2m[pick] ? st.ch[pick].pptr : st.ch[pick].mptr;
          end else begin
            next_st.xfer.src = st.ch[pick].mptr;
            next_st.xfer.dst = st.ch[pick].pptr;
          end
        end
      end
      ST_BUSY: begin
        // Item finishes even if enable dropped meanwhile
        if (xfer_done || !st.xfer.valid) begin
          next_st.xfer.valid = 1'b0;
          next_st.state      = ST_IDLE;
          if (st.xfer.valid) begin
            next_st.ch[c].cnt = st.ch[c].cnt - 8'h01;
            if (m2m[c]) begin
              next_st.ch[c].mptr = st.ch[c].mptr + 16'h0001;
              next_st.ch[c].pptr = step_dn ? st.ch[c].pptr - 16'h0001 : st.ch[c].pptr + 16'h0001;
            end else begin
              next_st.ch[c].mptr = step_dn ? st.ch[c].mptr - 16'h0001 : st.ch[c].mptr + 16'h0001;
            end
            if (st.ch[c].cnt - 8'h01 == (st.ch[c].init >> 1))
              next_st.ch[c].htf = 1'b1;
            if (st.ch[c].cnt == 8'h01) begin
              next_st.ch[c].tcf = 1'b1;
              if (st.ch[c].ctrl[CTL_CIRCULAR_ENABLE] && !m2m[c]) begin
                next_st.ch[c].cnt  = st.ch[c].init;
                next_st.ch[c].mptr = st.ch[c].mbase;
              end
            end
          end
        end
      end
      default: next_st.state = ST_IDLE;
    endcase
    if (reg_wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr == OFF_CTRL0 + 4'(i)) begin
          next_st.ch[i].ctrl = reg_wdata[6:0];
          if (i != MEM_CH)
            next_st.ch[i].ctrl[CTL_MEM] = 1'b0;
          if (reg_wdata[CTL_EN] && !st.ch[i].ctrl[CTL_EN] && st.ch[i].dirty) begin
            next_st.ch[i].cnt   = st.ch[i].init;
            next_st.ch[i].mptr  = st.ch[i].mbase;
            next_st.ch[i].pptr  = st.ch[i].pbase;
            next_st.ch[i].dirty = 1'b0;
          end
        end
        if (reg_addr == OFF_COUNT0 + 4'(i) && !st.ch[i].ctrl[CTL_EN]) begin
          next_st.ch[i].init  = reg_wdata[7:0];
          next_st.ch[i].cnt   = reg_wdata[7:0];
          next_st.ch[i].mptr  = st.ch[i].mbase;
          next_st.ch[i].pptr  = st.ch[i].pbase;
          next_st.ch[i].dirty = 1'b1;
        end
      end
      if (reg_addr == OFF_GLOBAL)
        next_st.gen = reg_wdata[0];
      if (reg_addr == OFF_REMAP)
        next_st.remap = reg_wdata[3:0];
    end
    if (reg_rd) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr == OFF_CTRL0 + 4'(i))
          next_st.rdata = {9'h000, st.ch[i].ctrl};
        if (reg_addr == OFF_COUNT0 + 4'(i))
          next_st.rdata = {8'h00, st.ch[i].cnt};
        if (reg_addr == OFF_STATUS)
          next_st.rdata[2*i +: 2] = {st.ch[i].tcf, st.ch[i].htf};
      end
      if (reg_addr == OFF_GLOBAL)
        next_st.rdata = {15'h0000, st.gen};
      if (reg_addr == OFF_REMAP)
        next_st.rdata = {12'h000, st.remap};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st       <= '0;
      st.remap <= REMAP_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++)
      irq_ch[i] = (st.ch[i].htf && st.ch[i].ctrl[CTL_HALF_TRANSFER_IRQ_ENABLE])
                | (st.ch[i].tcf && st.ch[i].ctrl[CTL_TRANSFER_COMPLETE_IRQ_ENABLE]);
  end

  assign reg_rdata = st.rdata;
  assign xfer      = st.xfer;

  m2m_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && st.ch[3].cnt == 8'h00 && m2m[3] && st.state == ST_IDLE) |=> !st.xfer.valid || st.xfer.ch != 2'd3)
    else $error("Memory channel moved past zero count");
  no_mem_reg_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !m2m[0] && !m2m[1] && !m2m[2])
    else $error("Regular channel in memory mode");
  circular_enable_reload_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && st.state == ST_BUSY && xfer_done && st.xfer.valid && st.ch[st.cur].cnt == 8'h01
     && st.ch[st.cur].ctrl[CTL_CIRCULAR_ENABLE] && !m2m[st.cur] && !reg_wr)
    |=> st.ch[$past(st.cur)].cnt == st.ch[$past(st.cur)].init)
    else $error("Circular count not reloaded");
  gen_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !st.gen && st.state == ST_IDLE) |=> st.state == ST_IDLE)
    else $error("Transfer began with global enable low");
  dec_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && st.state == ST_BUSY && xfer_done && st.xfer.valid && st.ch[st.cur].cnt > 8'h01 && !reg_wr)
    |=> st.ch[$past(st.cur)].cnt == $past(st.ch[st.cur].cnt) - 8'h01)
    else $error("Count did not drop by one");
  m2m_dst_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (st.xfer.valid && st.xfer.ch == 2'd3 && m2m[3]) |-> st.xfer.dst <= M2M_DST_HI)
    else $error("Memory destination out of window");
  per_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (st.xfer.valid && st.xfer.ch != 2'd3 && !st.ch[st.xfer.ch].ctrl[CTL_DIR])
    |-> st.xfer.src >= REG_PER_LO && st.xfer.src <= REG_PER_HI)
    else $error("Regular peripheral address out of window");
  busy_finish_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (st.state == ST_BUSY && st.xfer.valid && !xfer_done) |=> st.state == ST_BUSY)
    else $error("Item abandoned before completion");
  ch3_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (st.xfer.valid && st.xfer.ch == 2'd3 && !m2m[3] && !st.ch[3].ctrl[CTL_DIR])
    |-> st.xfer.src >= MEM_PER_LO && st.xfer.src <= MEM_PER_HI)
    else $error("Memory channel peripheral address out of window");
  ram_win_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (st.xfer.valid && st.xfer.ch != 2'd3 && !st.ch[st.xfer.ch].ctrl[CTL_DIR])
    |-> st.xfer.dst <= REG_RAM_HI)
    else $error("Regular memory address out of window");
  m2m_ptr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && st.state == ST_IDLE && pick_ok && pick == 2'd3 && m2m[3])
    |=> st.xfer.src == $past(st.ch[3].mptr) && st.xfer.dst == $past(st.ch[3].pptr))
    else $error("Memory copy pointers swapped");
  fresh_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && reg_wr && reg_addr == OFF_CTRL0 + 4'h3 && reg_wdata[CTL_EN] && !st.ch[3].ctrl[CTL_EN]
     && st.ch[3].dirty && st.state == ST_IDLE)
    |=> st.ch[3].cnt == st.ch[3].init && st.ch[3].pptr == st.ch[3].pbase)
    else $error("Rewritten count did not restart");
  half_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && st.state == ST_BUSY && xfer_done && st.xfer.valid
     && st.ch[st.cur].cnt - 8'h01 == (st.ch[st.cur].init >> 1))
    |=> st.ch[$past(st.cur)].htf)
    else $error("Half flag not raised");

endmodule

// ==== pkg/dmacm_pkg.sv ====
package dmacm_pkg;

  localparam int NUM_CH = 4;
  localparam int MEM_CH = 3;

  // Register offsets
  localparam logic [3:0] OFF_GLOBAL   = 4'h0;
  localparam logic [3:0] OFF_REMAP    = 4'h1;
  localparam logic [3:0] OFF_CTRL0    = 4'h4;
  localparam logic [3:0] OFF_COUNT0   = 4'h8;
  localparam logic [3:0] OFF_STATUS   = 4'hC;

  // Control field positions
  localparam int CTL_EN   = 0;
  localparam int CTL_DIR  = 1;
  localparam int CTL_CIRCULAR_ENABLE = 2;
  localparam int CTL_STEP = 3;
  localparam int CTL_MEM  = 4;
  localparam int CTL_HALF_TRANSFER_IRQ_ENABLE = 5;
  localparam int CTL_TRANSFER_COMPLETE_IRQ_ENABLE = 6;

  // Remap fields
  localparam int RMP_ADC_LO = 0;
  localparam int RMP_TIM_LO = 2;
  localparam logic [3:0] REMAP_RESET = 4'hC;

  // Address windows
  localparam logic [15:0] REG_PER_LO = 16'h5200;
  localparam logic [15:0] REG_PER_HI = 16'h53FF;
  localparam logic [15:0] REG_RAM_HI = 16'h07FF;
  localparam logic [15:0] MEM_PER_LO = 16'h4000;
  localparam logic [15:0] MEM_PER_HI = 16'h5FFF;
  localparam logic [15:0] M2M_DST_HI = 16'h1FFF;

  // Peripheral request bundle
  typedef struct packed {
    logic       adc_eoc;
    logic       timer4_update_request;
    logic [3:0] fixed_req;
  } dmacm_req_type;

  // Bus request toward memory/peripheral bus
  typedef struct packed {
    logic        valid;
    logic [1:0]  ch;
    logic [15:0] src;
    logic [15:0] dst;
  } dmacm_xfer_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } dmacm_state_type;

  typedef struct packed {
    logic [6:0]  ctrl;
    logic [7:0]  init;
    logic [7:0]  cnt;
    logic [15:0] pptr;
    logic [15:0] mptr;
    logic [15:0] mbase;
    logic [15:0] pbase;
    logic        dirty;
    logic        htf;
    logic        tcf;
  } dmacm_ch_type;

endpackage

// ==== tb/dmacm_bus_model.sv ====
`timescale 1ns/100ps
module dmacm_bus_model (
  input  wire logic                      mclk,        // System clock
  input  wire logic                      rst_b,       // Sync reset, active low
  input  wire dmacm_pkg::dmacm_xfer_type xfer,        // Item offered by the engine
  input  wire logic [3:0]                wait_cycles, // Extra cycles before finishing
  output      logic                      xfer_done    // One-cycle finish pulse
);
  import dmacm_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic       busy;
    logic       done;
  } dmacm_bus_state_type;
  dmacm_bus_state_type state, next_state;
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (xfer.valid && !state.busy) begin
      if (state.cnt == wait_cycles) begin
        next_state.done = 1'b1;
        next_state.busy = 1'b1;
        next_state.cnt = 4'h0;
      end else begin
        next_state.cnt = state.cnt + 4'h1;
      end
    end else if (!xfer.valid) begin
      next_state.busy = 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) state <= '0;
    else state <= next_state;
  end
  assign xfer_done = state.done;
endmodule

// ==== tb/test_dmacm_top.sv ====
`timescale 1ns/100ps
module test_dmacm_top;
  import dmacm_pkg::*;
  logic           mclk, rst_b, reg_wr, reg_rd, xfer_done;
  logic [3:0]     reg_addr, chan_req, irq_ch, wait_cycles, rmp;
  logic [15:0]    reg_wdata, reg_rdata;
  dmacm_req_type  preq [4];
  dmacm_xfer_type xfer;
  logic [33:0]    q [$];
  int             fail_count, samples_checked, seed, k;

  dmacm_top i_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(preq), .xfer(xfer),
    .xfer_done(xfer_done), .chan_req(chan_req), .irq_ch(irq_ch));
  dmacm_bus_model i_bus (.mclk(mclk), .rst_b(rst_b), .xfer(xfer), .wait_cycles(wait_cycles),
    .xfer_done(xfer_done));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Log every finished item as ch, src, dst
  always @(posedge mclk) if (rst_b && xfer.valid === 1'b1 && xfer_done === 1'b1) q.push_back(xfer[33:0]);

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    samples_checked++;
    if (got !== ex) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] ex, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(nm, ex, reg_rdata);
  endtask
  task automatic wait_items(input int n);
    int t;
    for (t = 0; t < 400 && q.size() < n; t++) @(posedge mclk);
    if (q.size() < n) begin
      fail_count++;
      $display("Error items expected %0d seen %0d", n, q.size());
      end_sim;
    end
  endtask
  task automatic check_items(input int n);
    for (int i = 0; i < n; i++) begin
      chk("ch", 16'h0003, {14'h0000, q[i][33:32]});
      chk("src", i[15:0], q[i][31:16]);
      chk("dst", i[15:0], q[i][15:0]);
    end
  endtask
  function automatic logic [3:0] exp_req(input logic [3:0] r);
    logic [3:0] v;
    for (int i = 0; i < 4; i++) begin
      v[i] = |preq[i].fixed_req | (preq[0].adc_eoc && r[1:0] == i) | (preq[0].timer4_update_request && r[3:2] == i);
    end
    return v;
  endfunction

  initial begin
    seed = 10351;
    fail_count = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    wait_cycles = 4'h0;
    for (k = 0; k < 4; k++) preq[k] = '0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFF_REMAP, 16'h000C, "remap");
    rd(OFF_STATUS, 16'h0000, "status");
    $display("test reset done");
    for (k = 0; k < 16; k++) begin
      rmp = k[3:0];
      wr(OFF_REMAP, {12'h000, rmp});
      for (int i = 0; i < 4; i++) preq[i] <= dmacm_req_type'($random(seed));
      @(posedge mclk);
      #1 chk("chan_req", {12'h000, exp_req(rmp)}, {12'h000, chan_req});
    end
    // One requester only, on channel 0
    for (k = 0; k < 4; k++) preq[k] <= '0;
    preq[0].fixed_req <= 4'h1;
    $display("test mapping done");
    wr(OFF_COUNT0, 16'h0003);
    wr(OFF_CTRL0, 16'h0011);
    rd(OFF_CTRL0, 16'h0001, "ctrl0");
    wr(OFF_GLOBAL, 16'h0001);
    repeat (20) @(posedge mclk);
    chk("items", 16'h0000, 16'(q.size()));
    rd(OFF_COUNT0, 16'h0003, "count0");
    wr(OFF_CTRL0, 16'h0000);
    $display("test window done");
    // Memory copy without a channel 3 request, circular left off
    wait_cycles <= 4'($random(seed) & 3);
    wr(OFF_COUNT0 + 4'h3, 16'h0004);
    wr(OFF_CTRL0 + 4'h3, 16'h0053);
    wait_items(4);
    repeat (20) @(posedge mclk);
    chk("items", 16'h0004, 16'(q.size()));
    check_items(4);
    rd(OFF_COUNT0 + 4'h3, 16'h0000, "count3");
    rd(OFF_STATUS, 16'h00C0, "status");
    chk("irq", 16'h0008, {12'h000, irq_ch});
    wr(OFF_STATUS, 16'h00C0);
    rd(OFF_STATUS, 16'h0000, "status");
    $display("test copy done");
    q.delete();
    wait_cycles <= 4'h6;
    wr(OFF_CTRL0 + 4'h3, 16'h0012);
    wr(OFF_COUNT0 + 4'h3, 16'h0006);
    wr(OFF_CTRL0 + 4'h3, 16'h0013);
    wait_items(2);
    for (k = 0; k < 50 && xfer.valid !== 1'b1; k++) @(posedge mclk);
    chk("in flight", 16'h0001, {15'h0000, xfer.valid});
    wr(OFF_GLOBAL, 16'h0000);
    repeat (40) @(posedge mclk);
    chk("items", 16'h0003, 16'(q.size()));
    rd(OFF_COUNT0 + 4'h3, 16'h0003, "count3");
    wr(OFF_GLOBAL, 16'h0001);
    wait_items(6);
    check_items(6);
    $display("test suspend done");
    wait_cycles <= 4'($random(seed) & 3);
    wr(OFF_CTRL0 + 4'h3, 16'h0012);
    wr(OFF_COUNT0 + 4'h3, 16'h0005);
    q.delete();
    wr(OFF_CTRL0 + 4'h3, 16'h0013);
    wait_items(2);
    wr(OFF_CTRL0 + 4'h3, 16'h0012);
    repeat (20) @(posedge mclk);
    q.delete();
    wr(OFF_COUNT0 + 4'h3, 16'h0002);
    wr(OFF_CTRL0 + 4'h3, 16'h0013);
    wait_items(2);
    repeat (20) @(posedge mclk);
    chk("items", 16'h0002, 16'(q.size()));
    check_items(2);
    $display("test restart done");
    end_sim;
  end
endmodule
